//--- rtl/sar_adc_consts.svh
// Purpose: offsets, field positions, reset values and timing counts of the converter sequencer
// Assumes: one 200 MHz clock that is also the converter's high-frequency clock
// Notes:   register indexes are word indexes; byte address is index times four
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH

// ==========================================================================
// register word indexes
`define IDX_CTRL_ONE   6'h0E
`define IDX_CTRL_TWO   6'h0F
`define IDX_RES_UPPER  6'h20
`define IDX_RES_LOWER  6'h21

// ==========================================================================
// field positions and reset values
`define CR1_START      7
`define CR1_MODE_HI    6
`define CR1_MODE_LO    5
`define CR1_AIDIS      4
`define CR1_CHAN_HI    3
`define CR2_LADDER     5
`define CR2_TIME_HI    3
`define CR2_TIME_LO    1
`define RES_FLAG       5
`define RES_BUSY       4
`define CTRL_ONE_RST   8'h10
`define CTRL_TWO_RST   6'h00

// ==========================================================================
// mode codes and bus responses
`define MODE_OFF       2'h0
`define MODE_SW        2'h1
`define MODE_REP       2'h3
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

// ==========================================================================
// conversion timing in high-frequency clock cycles
`define CYC_39         11'h027
`define CYC_78         11'h04E
`define CYC_156        11'h09C
`define CYC_312        11'h138
`define CYC_624        11'h270
`define CYC_1248       11'h4E0
`define CONV_STEPS     11'h00D
`define SAMPLE_STEPS   4'h3

`endif

//--- rtl/sar_adc_pkg.sv
// Purpose: types shared by the converter sequencer
// Assumes: constants come from sar_adc_consts.svh
// Notes:   sequencer phases only; codes left to the tool
package sar_adc_pkg;
    // ======================================================================
    // conversion phases
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_SAMPLE,
        PH_TRIAL
    } phase_t;
endpackage : sar_adc_pkg

//--- rtl/sar_adc_sequencer.sv
// Purpose: control and sequencing of a 10-bit successive-approximation converter
// Assumes: AXI4-Lite register port, inputs synchronous to mclk, mclk is the converter clock
// Notes:   3 sample steps then 10 trial steps, each step one thirteenth of the time
`timescale 1ns/1ps
`include "sar_adc_consts.svh"

module sar_adc_sequencer
    import sar_adc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              mclk,
    input  wire logic              srst,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              stopMode,
    input  wire logic              slowMode,
    input  wire logic              compHigh,
    output logic [9:0]             dacCode,
    output logic                   sampleHold,
    output logic [3:0]             analogChannel,
    output logic                   analogInputDisable,
    output logic                   ladderOn,
    output logic                   busy,
    output logic                   convDoneIrq
);

    // ======================================================================
    // declarations
    logic [7:0]        ctrlOne_q;
    logic [5:0]        ctrlTwo_q;
    logic [7:0]        resUpper_q;
    logic [1:0]        resLower_q;
    logic              endFlag_q;
    logic              irq_q;
    phase_t            phase_q;
    logic [10:0]       cycLeft_q;
    logic [10:0]       stepLeft_q;
    logic [3:0]        stepIdx_q;
    logic [9:0]        sar_q;
    logic [ADDR_W-1:0] awAddr_q;
    logic              awHeld_q;
    logic [31:0]       wData_q;
    logic [3:0]        wStrb_q;
    logic              wHeld_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;
    logic              lowPower;
    logic              wrFire;
    logic              rdFire;
    logic              wrOne;
    logic              wrTwo;
    logic              rdUpper;
    logic [1:0]        modeSel;
    logic [10:0]       convTotal;
    logic [10:0]       stepLen;
    logic              beginConv;
    logic              stepEnd;
    logic              lastStep;
    logic              finish;
    logic              abortMode;
    logic [9:0]        trial;
    logic [9:0]        decided;
    logic [10:0]       runLen_q;

    // conversion duration per time code; reserved codes take the longest
    function automatic logic [10:0] conv_cycles(input logic [2:0] code);
        unique case (code)
            3'h0:    conv_cycles = `CYC_39;
            3'h2:    conv_cycles = `CYC_78;
            3'h3:    conv_cycles = `CYC_156;
            3'h4:    conv_cycles = `CYC_312;
            3'h5:    conv_cycles = `CYC_624;
            3'h6:    conv_cycles = `CYC_1248;
            default: conv_cycles = `CYC_1248;
        endcase
    endfunction : conv_cycles

    // ======================================================================
    // decode and sequencing terms
    assign lowPower  = stopMode | slowMode;
    assign modeSel   = ctrlOne_q[`CR1_MODE_HI:`CR1_MODE_LO];
    assign convTotal = conv_cycles(ctrlTwo_q[`CR2_TIME_HI:`CR2_TIME_LO]);
    assign stepLen   = convTotal / `CONV_STEPS;
    // a pending start waits while mode is off or reserved
    assign beginConv = (phase_q == PH_IDLE) && ctrlOne_q[`CR1_START] && !lowPower
                       && (modeSel == `MODE_SW || modeSel == `MODE_REP);
    assign stepEnd   = (phase_q != PH_IDLE) && (stepLeft_q == 11'h000);
    assign lastStep  = (stepIdx_q == 4'h0);
    assign finish    = (phase_q == PH_TRIAL) && (cycLeft_q == 11'h000);
    assign abortMode = (phase_q != PH_IDLE) && (modeSel == `MODE_OFF);
    assign trial     = sar_q | (10'h001 << stepIdx_q);
    assign decided   = compHigh ? trial : sar_q;

    // ======================================================================
    // AXI4-Lite handshakes: address and data taken in either order
    assign awready = !awHeld_q && !bvalid_q;
    assign wready  = !wHeld_q && !bvalid_q;
    assign arready = !rvalid_q;
    assign wrFire  = awHeld_q && wHeld_q && !bvalid_q;
    assign rdFire  = arvalid && arready;
    assign wrOne   = wrFire && wStrb_q[0] && !lowPower
                     && (awAddr_q[7:0] == {`IDX_CTRL_ONE, 2'b00});
    assign wrTwo   = wrFire && wStrb_q[0] && !lowPower
                     && (awAddr_q[7:0] == {`IDX_CTRL_TWO, 2'b00});
    assign rdUpper = rdFire && (araddr[7:0] == {`IDX_RES_UPPER, 2'b00});
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;

    // write address and data holding
    always_ff @(posedge mclk) begin
        if (srst) begin
            awHeld_q <= 1'b0;
            awAddr_q <= '0;
            wHeld_q  <= 1'b0;
            wData_q  <= 32'h0000_0000;
            wStrb_q  <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= awaddr;
            end else if (wrFire) begin
                awHeld_q <= 1'b0;
            end
            if (wvalid && wready) begin
                wHeld_q <= 1'b1;
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end else if (wrFire) begin
                wHeld_q <= 1'b0;
            end
        end
    end

    // write response; unmapped addresses answer SLVERR
    always_ff @(posedge mclk) begin
        if (srst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `RESP_OKAY;
        end else if (wrFire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (awAddr_q[7:0] == {`IDX_CTRL_ONE, 2'b00} ||
                         awAddr_q[7:0] == {`IDX_CTRL_TWO, 2'b00} ||
                         awAddr_q[7:0] == {`IDX_RES_UPPER, 2'b00} ||
                         awAddr_q[7:0] == {`IDX_RES_LOWER, 2'b00}) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // read data, registered one cycle after the address is taken
    always_ff @(posedge mclk) begin
        if (srst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `RESP_OKAY;
        end else if (rdFire) begin
            rvalid_q <= 1'b1;
            rresp_q  <= `RESP_OKAY;
            unique case (araddr[7:0])
                {`IDX_CTRL_ONE, 2'b00}:  rdata_q <= {24'h00_0000, ctrlOne_q};
                {`IDX_CTRL_TWO, 2'b00}:  rdata_q <= {26'h000_0000, ctrlTwo_q};
                {`IDX_RES_UPPER, 2'b00}: rdata_q <= {24'h00_0000, resUpper_q};
                {`IDX_RES_LOWER, 2'b00}: rdata_q <= {24'h00_0000, resLower_q, endFlag_q,
                                                     busy, 4'h0};
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= `RESP_SLVERR;
                end
            endcase
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ======================================================================
    // control registers; stop/slow forces them to their initial values
    always_ff @(posedge mclk) begin
        if (srst || lowPower) begin
            ctrlOne_q <= `CTRL_ONE_RST;
        end else if (wrOne) begin
            ctrlOne_q <= wData_q[7:0];
        end else if (beginConv) begin
            ctrlOne_q[`CR1_START] <= 1'b0;
        end
    end

    // second control register keeps bits 5:0; upper bits read as zero
    always_ff @(posedge mclk) begin
        if (srst || lowPower) begin
            ctrlTwo_q <= `CTRL_TWO_RST;
        end else if (wrTwo) begin
            ctrlTwo_q <= wData_q[5:0];
        end
    end

    // ======================================================================
    // sequencer: sample steps, then one trial bit per step
    always_ff @(posedge mclk) begin
        if (srst || lowPower) begin
            phase_q    <= PH_IDLE;
            cycLeft_q  <= 11'h000;
            stepLeft_q <= 11'h000;
            stepIdx_q  <= 4'h0;
            sar_q      <= 10'h000;
        end else if (beginConv || (finish && modeSel == `MODE_REP)) begin
            phase_q    <= PH_SAMPLE;
            cycLeft_q  <= convTotal - 11'h001;
            stepLeft_q <= stepLen - 11'h001;
            stepIdx_q  <= `SAMPLE_STEPS - 4'h1;
            sar_q      <= 10'h000;
        end else if (abortMode || finish) begin
            phase_q <= PH_IDLE;
        end else if (phase_q != PH_IDLE) begin
            cycLeft_q <= cycLeft_q - 11'h001;
            if (stepEnd) begin
                stepLeft_q <= stepLen - 11'h001;
                if (phase_q == PH_SAMPLE && lastStep) begin
                    phase_q   <= PH_TRIAL;
                    stepIdx_q <= 4'h9;
                end else begin
                    stepIdx_q <= stepIdx_q - 4'h1;
                end
                if (phase_q == PH_TRIAL) begin
                    sar_q <= decided;
                end
            end else begin
                stepLeft_q <= stepLeft_q - 11'h001;
            end
        end
    end

    // ======================================================================
    // result store: only a full conversion reaches the registers
    always_ff @(posedge mclk) begin
        if (srst || lowPower) begin
            resUpper_q <= 8'h00;
            resLower_q <= 2'h0;
        end else if (finish && !abortMode) begin
            resUpper_q <= decided[9:2];
            resLower_q <= decided[1:0];
        end
    end

    // end flag: completion wins over a read in the same cycle
    always_ff @(posedge mclk) begin
        if (srst || lowPower) begin
            endFlag_q <= 1'b0;
        end else if (finish && !abortMode) begin
            endFlag_q <= 1'b1;
        end else if (rdUpper || beginConv) begin
            endFlag_q <= 1'b0;
        end
    end

    // interrupt pulse in the cycle each completion sets the flag, even if it is already set
    always_ff @(posedge mclk) begin
        if (srst || lowPower) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= finish && !abortMode;
        end
    end

    // ======================================================================
    // analog side controls
    assign busy               = (phase_q != PH_IDLE);
    assign convDoneIrq        = irq_q;
    assign sampleHold         = (phase_q == PH_SAMPLE);
    assign dacCode            = (phase_q == PH_TRIAL) ? trial : 10'h000;
    assign analogChannel      = ctrlOne_q[`CR1_CHAN_HI:0];
    assign analogInputDisable = ctrlOne_q[`CR1_AIDIS];
    // ladder drops in stop/slow whatever the control bit says
    assign ladderOn = !lowPower && (ctrlTwo_q[`CR2_LADDER] || busy);

    // ======================================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // cycles since the running conversion began; a counter keeps the check cheap
    always_ff @(posedge mclk) begin
        if (srst || beginConv || (finish && modeSel == `MODE_REP)) begin
            runLen_q <= 11'h001;
        end else begin
            runLen_q <= runLen_q + 11'h001;
        end
    end

    property p_start_clears;
        beginConv |=> !ctrlOne_q[`CR1_START] && busy;
    endproperty
    a_start_clears: assert property (p_start_clears) else $error("start bit not cleared");

    property p_flag_irq;
        $rose(endFlag_q) |-> $past(finish) && !$past(lowPower);
    endproperty
    a_flag_irq: assert property (p_flag_irq) else $error("flag rose without completion");

    property p_irq_pulse;
        convDoneIrq |-> endFlag_q && $rose(endFlag_q) || (endFlag_q && $past(endFlag_q));
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt without end flag");

    property p_irq_single;
        convDoneIrq |=> !convDoneIrq;
    endproperty
    a_irq_single: assert property (p_irq_single) else $error("interrupt longer than one cycle");

    property p_read_clears;
        rdUpper && !finish |=> !endFlag_q;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read left flag set");

    property p_abort_keeps;
        abortMode && !lowPower |=> !busy && $stable(resUpper_q) && !convDoneIrq;
    endproperty
    a_abort_keeps: assert property (p_abort_keeps) else $error("abort stored result");

    property p_single_once;
        finish && modeSel == `MODE_SW |=> !busy [*2];
    endproperty
    a_single_once: assert property (p_single_once) else $error("single mode converted again");

    property p_repeat;
        finish && modeSel == `MODE_REP && !lowPower |=> phase_q == PH_SAMPLE;
    endproperty
    a_repeat: assert property (p_repeat) else $error("repeat did not restart");

    property p_low_power;
        lowPower |=> !busy && ctrlOne_q == `CTRL_ONE_RST && !ladderOn && !endFlag_q;
    endproperty
    a_low_power: assert property (p_low_power) else $error("stop or slow not honoured");

    property p_duration;
        finish |-> runLen_q == convTotal;
    endproperty
    a_duration: assert property (p_duration) else $error("conversion time wrong");

    property p_keep_result;
        beginConv |=> $stable(resUpper_q);
    endproperty
    a_keep_result: assert property (p_keep_result) else $error("old result lost on start");

    c_single: cover property (finish && modeSel == `MODE_SW);
    c_repeat: cover property (finish && modeSel == `MODE_REP);
    c_abort:  cover property (abortMode);
    c_stop:   cover property (busy && lowPower);

endmodule : sar_adc_sequencer

//--- tb/sar_adc_sequencer_bench.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: registers reached over AXI4-Lite; comparator modelled from a target code
// Notes:   table rows cover every time code; awkward cases follow the loop
`timescale 1ns/1ps
`include "sar_adc_consts.svh"

module sar_adc_sequencer_bench;
    // ======================================================================
    // stimulus table and signals
    typedef struct packed {
        logic [2:0]  timeCode;
        logic [3:0]  chan;
        logic [9:0]  target;
        logic        ladder;
        logic [10:0] cycles;
    } row_t;

    localparam logic [7:0] ADDR_CR1 = 8'(`IDX_CTRL_ONE * 4);
    localparam logic [7:0] ADDR_CR2 = 8'(`IDX_CTRL_TWO * 4);
    localparam logic [7:0] ADDR_UP  = 8'(`IDX_RES_UPPER * 4);
    localparam logic [7:0] ADDR_LOW = 8'(`IDX_RES_LOWER * 4);
    localparam logic [7:0] ADDR_BAD = 8'hF0;

    // reserved time codes 1 and 7 run the longest count
    row_t rows [8] = '{
        '{3'h0, 4'h3, 10'h3FF, 1'b0, `CYC_39},
        '{3'h1, 4'h8, 10'h000, 1'b1, `CYC_1248},
        '{3'h2, 4'h1, 10'h155, 1'b0, `CYC_78},
        '{3'h3, 4'h7, 10'h2AA, 1'b1, `CYC_156},
        '{3'h4, 4'h0, 10'h201, 1'b0, `CYC_312},
        '{3'h5, 4'h5, 10'h0FE, 1'b0, `CYC_624},
        '{3'h6, 4'h2, 10'h1C3, 1'b1, `CYC_1248},
        '{3'h7, 4'h6, 10'h37C, 1'b0, `CYC_1248}
    };

    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0]  wstrb = 4'hF;
    logic        stopMode = 1'b0, slowMode = 1'b0, compHigh = 1'b0;
    logic [9:0]  target = 10'h000;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [9:0]  dacCode;
    logic [3:0]  analogChannel;
    logic        sampleHold, analogInputDisable, ladderOn, busy, convDoneIrq;
    int          irqTotal = 0, cycleCount = 0, numErrors = 0, totalChecks = 0;
    int          n, k, base;

    sar_adc_sequencer #(.ADDR_W(8)) sar_adc_sequencer_inst (
        .mclk(mclk), .srst(srst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .stopMode(stopMode), .slowMode(slowMode), .compHigh(compHigh), .dacCode(dacCode),
        .sampleHold(sampleHold), .analogChannel(analogChannel),
        .analogInputDisable(analogInputDisable), .ladderOn(ladderOn), .busy(busy),
        .convDoneIrq(convDoneIrq)
    );

    always #2.5 mclk = ~mclk;

    // ======================================================================
    // comparator model, interrupt count, hang guard
    // registered comparator lags a cycle; every step is at least three long
    always @(posedge mclk) begin
        compHigh <= (target >= dacCode);
        if (convDoneIrq === 1'b1) irqTotal <= irqTotal + 1;
        cycleCount <= cycleCount + 1;
        if (cycleCount == 30000) begin
            numErrors++;
            wrapUp();
        end
    end

    // ======================================================================
    // compare, bus and closing tasks
    task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : checkWord

    task automatic checkBit(input logic got, input logic exp);
        checkWord({31'h0, got}, {31'h0, exp});
    endtask : checkBit

    // offers address and data together, each dropped once taken
    task automatic busWrite(input logic [7:0] addr, input logic [7:0] data,
                            input logic [1:0] resp);
        awaddr  <= addr;
        awvalid <= 1'b1;
        wdata   <= {24'h0, data};
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        checkWord({30'h0, bresp}, {30'h0, resp});
    endtask : busWrite

    task automatic readCheck(input logic [7:0] addr, input logic [7:0] exp,
                             input logic [1:0] resp);
        araddr  <= addr;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        checkWord(rdata, {24'h0, exp});
        checkWord({30'h0, rresp}, {30'h0, resp});
    endtask : readCheck

    task automatic waitIrq();
        do @(posedge mclk); while (convDoneIrq !== 1'b1);
    endtask : waitIrq

    task automatic wrapUp();
        $display("checks %0d errors %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrapUp

    // ======================================================================
    // main sequence
    initial begin
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        // idle outputs and register reset values
        checkBit(busy, 1'b0);
        checkBit(convDoneIrq, 1'b0);
        checkBit(ladderOn, 1'b0);
        checkBit(analogInputDisable, 1'b1);
        checkWord({28'h0, analogChannel}, 32'h0);
        checkWord({22'h0, dacCode}, 32'h0);
        readCheck(ADDR_CR1, `CTRL_ONE_RST, `RESP_OKAY);
        readCheck(ADDR_CR2, {2'b00, `CTRL_TWO_RST}, `RESP_OKAY);
        readCheck(ADDR_UP, 8'h00, `RESP_OKAY);
        readCheck(ADDR_BAD, 8'h00, `RESP_SLVERR);
        busWrite(ADDR_BAD, 8'h55, `RESP_SLVERR);

        // one software-start conversion per row, configured before start
        foreach (rows[i]) begin
            target <= rows[i].target;
            base = irqTotal;
            busWrite(ADDR_CR2, {2'b00, rows[i].ladder, 1'b0, rows[i].timeCode, 1'b0},
                     `RESP_OKAY);
            busWrite(ADDR_CR1, {3'b101, 1'b0, rows[i].chan}, `RESP_OKAY);
            @(posedge mclk);
            checkBit(ladderOn, 1'b1);
            checkBit(sampleHold, 1'b1);
            n = 1;
            do begin // bus left idle while converting
                @(posedge mclk);
                if (busy === 1'b1) n++;
            end while (convDoneIrq !== 1'b1);
            checkWord(32'(n), {21'h0, rows[i].cycles});
            checkBit(busy, 1'b0);
            checkBit(sampleHold, 1'b0);
            checkWord({28'h0, analogChannel}, {28'h0, rows[i].chan});
            checkBit(analogInputDisable, 1'b0);
            @(posedge mclk);
            checkBit(convDoneIrq, 1'b0);
            readCheck(ADDR_LOW, {rows[i].target[1:0], 6'h20}, `RESP_OKAY);
            readCheck(ADDR_UP, rows[i].target[9:2], `RESP_OKAY);
            readCheck(ADDR_LOW, {rows[i].target[1:0], 6'h00}, `RESP_OKAY);
            readCheck(ADDR_CR1, {3'b001, 1'b0, rows[i].chan}, `RESP_OKAY);
            checkBit(ladderOn, rows[i].ladder);
            checkWord(32'(irqTotal - base), 32'h1);
        end

        // restart before the result is read: old result kept until done
        target <= 10'h0F0;
        busWrite(ADDR_CR2, 8'h00, `RESP_OKAY);
        busWrite(ADDR_CR1, 8'hA4, `RESP_OKAY);
        waitIrq();
        target <= 10'h30F;
        busWrite(ADDR_CR1, 8'hA4, `RESP_OKAY);
        readCheck(ADDR_LOW, 8'h10, `RESP_OKAY);
        readCheck(ADDR_UP, 8'h3C, `RESP_OKAY);
        waitIrq();
        readCheck(ADDR_UP, 8'hC3, `RESP_OKAY);

        // repeat mode runs three back to back, then disable aborts mid-run
        target <= 10'h155;
        busWrite(ADDR_CR1, 8'hE4, `RESP_OKAY);
        n = 0;
        k = 0;
        do begin
            @(posedge mclk);
            if (busy !== 1'b1) k++;
            if (convDoneIrq === 1'b1) n++;
        end while (n < 3);
        checkWord(32'(k), 32'h0);
        target <= 10'h2AA;
        busWrite(ADDR_CR1, 8'h04, `RESP_OKAY);
        // taken only now: the third pulse is counted after the edge that ended the loop
        base = irqTotal;
        repeat (2) @(posedge mclk);
        checkBit(busy, 1'b0);
        repeat (100) @(posedge mclk);
        checkWord(32'(irqTotal - base), 32'h0);
        readCheck(ADDR_UP, 8'h55, `RESP_OKAY);
        readCheck(ADDR_LOW, 8'h40, `RESP_OKAY);

        // stop, then slow, entered mid-conversion with the ladder held on
        for (int m = 0; m < 2; m++) begin
            busWrite(ADDR_CR2, 8'h2C, `RESP_OKAY);
            busWrite(ADDR_CR1, 8'hA5, `RESP_OKAY);
            repeat (20) @(posedge mclk);
            checkBit(busy, 1'b1);
            base = irqTotal;
            stopMode <= (m == 0);
            slowMode <= (m == 1);
            repeat (2) @(posedge mclk);
            checkBit(busy, 1'b0);
            checkBit(ladderOn, 1'b0);
            busWrite(ADDR_CR1, 8'hA5, `RESP_OKAY);
            readCheck(ADDR_CR1, `CTRL_ONE_RST, `RESP_OKAY);
            readCheck(ADDR_CR2, 8'h00, `RESP_OKAY);
            readCheck(ADDR_UP, 8'h00, `RESP_OKAY);
            stopMode <= 1'b0;
            slowMode <= 1'b0;
            k = 0;
            repeat (100) begin
                @(posedge mclk);
                if (busy !== 1'b0) k++;
            end
            checkWord(32'(k), 32'h0);
            checkWord(32'(irqTotal - base), 32'h0);
        end
        wrapUp();
    end
endmodule : sar_adc_sequencer_bench
